// ### hw/ocm_pkg.sv
// Constants and types shared by the output compare channel.
package ocm_pkg;

   // ==========================================================================
   // Register map, byte addresses on the Avalon-MM slave.
   localparam logic [3:0]  OCM_ADDR_CTRL      = 4'h0;
   localparam logic [3:0]  OCM_ADDR_PRIMARY   = 4'h4;
   localparam logic [3:0]  OCM_ADDR_SECONDARY = 4'h8;
   localparam logic [3:0]  OCM_ADDR_STATUS    = 4'hc;
   localparam int          OCM_ADDR_W         = 4;
   localparam int          OCM_DATA_W         = 32;
   localparam int          OCM_CNT_W          = 16;

   // ==========================================================================
   // Control register fields.
   localparam int          OCM_CTRL_MODE_LSB  = 0;
   localparam int          OCM_CTRL_MODE_MSB  = 2;
   localparam int          OCM_CTRL_TSEL_BIT  = 3;
   localparam int          OCM_CTRL_FAULT_BIT = 4;

   // Status register fields.
   localparam int          OCM_STAT_PIN_BIT   = 0;
   localparam int          OCM_STAT_OE_BIT    = 1;
   localparam int          OCM_STAT_DONE_BIT  = 2;

   // ==========================================================================
   // Reset values.
   localparam logic [2:0]  OCM_MODE_RST       = 3'h0;
   localparam logic        OCM_TSEL_RST       = 1'b0;
   localparam logic [15:0] OCM_CMP_RST        = 16'h0000;

   // ==========================================================================
   // Values of the compare mode field.
   localparam logic [2:0]  OCM_MODE_OFF       = 3'h0;
   localparam logic [2:0]  OCM_MODE_LOW       = 3'h1;
   localparam logic [2:0]  OCM_MODE_HIGH      = 3'h2;
   localparam logic [2:0]  OCM_MODE_TOGGLE    = 3'h3;
   localparam logic [2:0]  OCM_MODE_SINGLE    = 3'h4;
   localparam logic [2:0]  OCM_MODE_CONT      = 3'h5;
   localparam logic [2:0]  OCM_MODE_PWM       = 3'h6;
   localparam logic [2:0]  OCM_MODE_PWM_FLT   = 3'h7;

   // Pulse generator states.
   typedef enum logic [1:0] {
      OCM_PS_WAIT,
      OCM_PS_HIGH,
      OCM_PS_DONE
   } ocm_pulse_state_t;

endpackage

// ### hw/ocm_match.sv
// Edge-qualified equality detector between a timer count and a compare value.
module ocm_match
   import ocm_pkg::*;
(
   // Clock and reset
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_rst,
   input  wire logic                 i_ce,
   // Compare operands
   input  wire logic [OCM_CNT_W-1:0] i_count,
   input  wire logic [OCM_CNT_W-1:0] i_value,
   // Result
   output logic                      o_hit
);

   logic [OCM_CNT_W-1:0] prev_q;

   // =========================================================================
   // A match fires once, in the cycle after the count first equals the value.
   // A stopped timer that rests on the value therefore does not repeat it.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         prev_q <= OCM_CMP_RST;
         o_hit  <= 1'b0;
      end else if (i_ce) begin
         prev_q <= i_count;
         o_hit  <= (i_count == i_value) && (i_count != prev_q);
      end
   end

endmodule

// ### hw/ocm_channel.sv
// Output compare channel: match, pulse and buffered PWM modes with fault cut-off.
//
// Chosen here: register access over Avalon-MM and the placing of the registers.

// Function
// - Channel compares against timer_a or timer_b count, picked by timer_select.
// - timer_select resets to zero so timer_a is the timebase after reset.
// - Modes 001, 010, 011 drive the pin low, high or toggle on match.
// - Simple modes act when the selected count equals primary_compare_value.
// - In simple modes a wrap to zero without a match leaves the pin level unchanged.
// - Mode 100 gives one pulse, mode 101 a continuous pulse train.
// - Pulse starts on primary match and ends on secondary match.
// - After one single pulse, none more until mode 100 is written again.
// - Continuous mode repeats the pulse every timer cycle while selected.
// - Modes 110, 111 are PWM; primary is read-only, buffered by secondary.
// - Mode 111 with fault_input low puts the pin in high impedance at once.
// - fault_flag, control bit 4, is set when a fault occurred in mode 111.
// - Fault state holds until fault clears and PWM mode is rewritten.
module ocm_channel
   import ocm_pkg::*;
(
   // Clock, reset and clock enable
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst,
   input  wire logic                  i_ce,
   // Avalon-MM slave
   input  wire logic [OCM_ADDR_W-1:0] i_avs_address,
   input  wire logic                  i_avs_read,
   input  wire logic                  i_avs_write,
   input  wire logic [3:0]            i_avs_byteenable,
   input  wire logic [OCM_DATA_W-1:0] i_avs_writedata,
   output logic      [OCM_DATA_W-1:0] o_avs_readdata,
   output logic                       o_avs_waitrequest,
   // Shared timer counts
   input  wire logic [OCM_CNT_W-1:0]  i_timer_a_count,
   input  wire logic [OCM_CNT_W-1:0]  i_timer_b_count,
   // Fault input, active low
   input  wire logic                  i_fault_input_n,
   // Compare output pin
   output logic                       o_compare_output_pin,
   output logic                       o_compare_output_oe
);

   // =========================================================================
   // Declarations.
   logic [2:0]           mode_q;
   logic                 tsel_q;
   logic                 fault_q;
   logic [OCM_CNT_W-1:0] primary_q;
   logic [OCM_CNT_W-1:0] secondary_q;
   logic                 pin_q;
   logic                 ack_q;
   ocm_pulse_state_t     pstate_q;
   ocm_pulse_state_t     pstate_d;
   logic [OCM_CNT_W-1:0] count_sel;
   logic                 hit_pri;
   logic                 hit_sec;
   logic                 hit_wrap;
   logic                 bus_req;
   logic                 bus_ack;
   logic                 wr_ctrl;
   logic                 wr_pri;
   logic                 wr_sec;
   logic [2:0]           wr_mode;
   logic                 is_pwm;
   logic                 is_pulse;
   logic                 pin_d;
   logic                 fault_now;

   // =========================================================================
   // Byte-lane merge of a write into a 16-bit register.
   function automatic logic [OCM_CNT_W-1:0] merge16(
      input logic [OCM_CNT_W-1:0]  old_val,
      input logic [OCM_DATA_W-1:0] wdata,
      input logic [3:0]            be
   );
      logic [OCM_CNT_W-1:0] res;
      res = old_val;
      if (be[0]) begin
         res[7:0] = wdata[7:0];
      end
      if (be[1]) begin
         res[15:8] = wdata[15:8];
      end
      return res;
   endfunction

   // Mode class decode, used by the compare value logic and the fault latch.
   function automatic logic mode_is_pwm(input logic [2:0] m);
      return (m == OCM_MODE_PWM) || (m == OCM_MODE_PWM_FLT);
   endfunction

   // =========================================================================
   // Avalon-MM handshake: every access takes exactly one wait state. The
   // acknowledge only counts while the clock enable is high, so a frozen
   // channel keeps the master waiting instead of losing its write.
   assign bus_req           = i_avs_read | i_avs_write;
   assign bus_ack           = ack_q & i_ce;
   assign o_avs_waitrequest = bus_req & ~bus_ack;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         ack_q <= 1'b0;
      end else if (i_ce) begin
         ack_q <= bus_req & ~ack_q;
      end
   end

   // Writes take effect at the edge where waitrequest is seen low.
   assign wr_ctrl = i_avs_write & bus_ack & (i_avs_address == OCM_ADDR_CTRL)
                    & i_avs_byteenable[0];
   assign wr_pri  = i_avs_write & bus_ack & (i_avs_address == OCM_ADDR_PRIMARY);
   assign wr_sec  = i_avs_write & bus_ack & (i_avs_address == OCM_ADDR_SECONDARY);
   assign wr_mode = i_avs_writedata[OCM_CTRL_MODE_MSB:OCM_CTRL_MODE_LSB];

   // =========================================================================
   // Read data register. The value is captured at the edge that first sees the
   // read and stands through the acknowledge cycle; otherwise the bus reads zero.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_avs_readdata <= '0;
      end else if (i_ce) begin
         o_avs_readdata <= '0;
         if (i_avs_read & ~ack_q) begin
            case (i_avs_address)
               OCM_ADDR_CTRL: begin
                  o_avs_readdata[OCM_CTRL_MODE_MSB:OCM_CTRL_MODE_LSB] <= mode_q;
                  o_avs_readdata[OCM_CTRL_TSEL_BIT]                   <= tsel_q;
                  o_avs_readdata[OCM_CTRL_FAULT_BIT]                  <= fault_q;
               end
               OCM_ADDR_PRIMARY: begin
                  o_avs_readdata[OCM_CNT_W-1:0] <= primary_q;
               end
               OCM_ADDR_SECONDARY: begin
                  o_avs_readdata[OCM_CNT_W-1:0] <= secondary_q;
               end
               OCM_ADDR_STATUS: begin
                  o_avs_readdata[OCM_STAT_PIN_BIT]  <= pin_q;
                  o_avs_readdata[OCM_STAT_OE_BIT]   <= ~fault_q;
                  o_avs_readdata[OCM_STAT_DONE_BIT] <= (pstate_q == OCM_PS_DONE);
               end
               default: begin
                  o_avs_readdata <= '0;
               end
            endcase
         end
      end
   end

   // =========================================================================
   // Control register: mode and timebase select.
   // Byte lane 0 carries the whole field; the fault flag is read only.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         mode_q <= OCM_MODE_RST;
         tsel_q <= OCM_TSEL_RST;
      end else if (wr_ctrl) begin
         mode_q <= wr_mode;
         tsel_q <= i_avs_writedata[OCM_CTRL_TSEL_BIT];
      end
   end

   // Mode classes used across the pulse and compare logic.
   assign is_pwm   = mode_is_pwm(mode_q);
   assign is_pulse = (mode_q == OCM_MODE_SINGLE) || (mode_q == OCM_MODE_CONT);

   // =========================================================================
   // Timebase select and match detection.
   // A third comparator against zero marks the period restart on which PWM
   // reloads its duty.
   assign count_sel = tsel_q ? i_timer_b_count : i_timer_a_count;

   ocm_match u_match_pri (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_count   (count_sel),
      .i_value   (primary_q),
      .o_hit     (hit_pri)
   );

   ocm_match u_match_sec (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_count   (count_sel),
      .i_value   (secondary_q),
      .o_hit     (hit_sec)
   );

   ocm_match u_match_wrap (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_count   (count_sel),
      .i_value   (OCM_CMP_RST),
      .o_hit     (hit_wrap)
   );

   // =========================================================================
   // Compare values. Primary is locked against software in PWM modes and
   // is reloaded from secondary at each period restart instead.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         primary_q <= OCM_CMP_RST;
      end else if (i_ce) begin
         if (is_pwm && hit_wrap) begin
            primary_q <= secondary_q;
         end else if (wr_pri && !is_pwm) begin
            primary_q <= merge16(primary_q, i_avs_writedata, i_avs_byteenable);
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         secondary_q <= OCM_CMP_RST;
      end else if (wr_sec) begin
         secondary_q <= merge16(secondary_q, i_avs_writedata, i_avs_byteenable);
      end
   end

   // =========================================================================
   // Pulse sequencer for the dual compare modes.
   // Any control write rearms a finished single pulse, and leaving the pulse
   // modes parks the sequencer in its waiting state.
   always_comb begin
      pstate_d = pstate_q;
      case (pstate_q)
         OCM_PS_WAIT: begin
            if (is_pulse && hit_pri) begin
               pstate_d = OCM_PS_HIGH;
            end
         end
         OCM_PS_HIGH: begin
            if (hit_sec) begin
               if (mode_q == OCM_MODE_SINGLE) begin
                  pstate_d = OCM_PS_DONE;
               end else begin
                  pstate_d = OCM_PS_WAIT;
               end
            end
         end
         OCM_PS_DONE: begin
            pstate_d = OCM_PS_DONE;
         end
         default: begin
            pstate_d = OCM_PS_WAIT;
         end
      endcase
      if (!is_pulse) begin
         pstate_d = OCM_PS_WAIT;
      end
      if (wr_ctrl) begin
         pstate_d = OCM_PS_WAIT;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         pstate_q <= OCM_PS_WAIT;
      end else if (i_ce) begin
         pstate_q <= pstate_d;
      end
   end

   // =========================================================================
   // Output pin level. The pin follows a match two edges after the count takes
   // the value: one edge in the comparator and one in the pin register.
   always_comb begin
      pin_d = pin_q;
      case (mode_q)
         OCM_MODE_OFF: begin
            pin_d = 1'b0;
         end
         OCM_MODE_LOW: begin
            if (hit_pri) begin
               pin_d = 1'b0;
            end
         end
         OCM_MODE_HIGH: begin
            if (hit_pri) begin
               pin_d = 1'b1;
            end
         end
         OCM_MODE_TOGGLE: begin
            if (hit_pri) begin
               pin_d = ~pin_q;
            end
         end
         OCM_MODE_SINGLE, OCM_MODE_CONT: begin
            pin_d = (pstate_d == OCM_PS_HIGH);
         end
         OCM_MODE_PWM, OCM_MODE_PWM_FLT: begin
            // A restart wins over a duty match in the same cycle, and a duty of
            // zero keeps the pin low for the whole period.
            if (hit_wrap) begin
               pin_d = (secondary_q != OCM_CMP_RST);
            end else if (hit_pri) begin
               pin_d = 1'b0;
            end
         end
         default: begin
            pin_d = pin_q;
         end
      endcase
   end

   // A wrap without a match leaves the level as it is in the simple modes.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         pin_q <= 1'b0;
      end else if (i_ce) begin
         pin_q <= pin_d;
      end
   end

   // =========================================================================
   // Fault latch. A low fault input in mode 111 sets it; only a rewrite of a
   // PWM mode while the input is already high releases it. Set wins.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         fault_q <= 1'b0;
      end else if (i_ce) begin
         if (fault_now) begin
            fault_q <= 1'b1;
         end else if (wr_ctrl && mode_is_pwm(wr_mode) && i_fault_input_n) begin
            fault_q <= 1'b0;
         end
      end
   end

   // =========================================================================
   // Pin drivers. The enable drops combinationally on a fault so that the
   // power stage is released in the same cycle the fault is seen; from the
   // next edge on the latch keeps it released.
   assign fault_now            = (mode_q == OCM_MODE_PWM_FLT) & ~i_fault_input_n;
   assign o_compare_output_pin = pin_q;
   assign o_compare_output_oe  = ~fault_q & ~fault_now;

endmodule

// ### test/ocm_channel_sva.sv
// Port-level assertions for the output compare channel.
module ocm_channel_sva
   import ocm_pkg::*;
(
   // Clock and reset
   input wire logic                  i_clk_sys,
   input wire logic                  i_rst,
   // Register bus
   input wire logic [OCM_ADDR_W-1:0] i_avs_address,
   input wire logic                  i_avs_read,
   input wire logic                  i_avs_write,
   input wire logic [OCM_DATA_W-1:0] o_avs_readdata,
   input wire logic                  o_avs_waitrequest,
   // Timers, fault and pin
   input wire logic [OCM_CNT_W-1:0]  i_timer_a_count,
   input wire logic [OCM_CNT_W-1:0]  i_timer_b_count,
   input wire logic                  i_fault_input_n,
   input wire logic                  o_compare_output_pin,
   input wire logic                  o_compare_output_oe
);
   // ==========
   // Helpers and properties
   logic [OCM_CNT_W-1:0] cnt_a_q;
   logic [OCM_CNT_W-1:0] cnt_b_q;
   logic                 wr_ok;
   logic                 ctl_wr;
   logic                 cnt_evt;
   assign wr_ok   = i_avs_write && !o_avs_waitrequest;
   assign ctl_wr  = wr_ok && i_avs_address == OCM_ADDR_CTRL;
   assign cnt_evt = i_timer_a_count != cnt_a_q || i_timer_b_count != cnt_b_q;
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         cnt_a_q <= '0;
         cnt_b_q <= '0;
      end else begin
         cnt_a_q <= i_timer_a_count;
         cnt_b_q <= i_timer_b_count;
      end
   end
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   sequence s_ack;
      o_avs_waitrequest ##1 !o_avs_waitrequest;
   endsequence
   AST_BUS_WAIT:
      assert property ($rose(i_avs_read || i_avs_write) |-> s_ack) else $error("no ack");
   AST_BUS_IDLE:
      assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest) else $error("idle wait");
   AST_RD_ZERO:
      assert property (!(i_avs_read && !o_avs_waitrequest) |-> o_avs_readdata == '0)
      else $error("readdata not zero");
   AST_RD_UPPER:
      assert property (i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:16] == 16'h0000)
      else $error("upper bits set");
   AST_OE_CAUSE:
      assert property ($fell(o_compare_output_oe) |-> !i_fault_input_n) else $error("oe fell");
   AST_OE_HOLD:
      assert property (!o_compare_output_oe && !ctl_wr |=> !o_compare_output_oe)
      else $error("oe released");
   AST_OE_FREE:
      assert property ($rose(o_compare_output_oe) |-> i_fault_input_n && $past(ctl_wr))
      else $error("oe rose");
   AST_PIN_CAUSE:
      assert property ($changed(o_compare_output_pin) |->
                       $past(cnt_evt, 2) || $past(wr_ok) || $past(wr_ok, 2))
      else $error("pin moved");
endmodule

bind ocm_channel ocm_channel_sva ocm_channel_sva_inst (
   .i_clk_sys, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
   .o_avs_readdata, .o_avs_waitrequest, .i_timer_a_count, .i_timer_b_count,
   .i_fault_input_n, .o_compare_output_pin, .o_compare_output_oe
);

// ### test/ocm_load.sv
// Load model on the compare pin; reports an overload as a fault.
module ocm_load
(
   // Clock
   input  wire logic i_clk_sys,
   // Pin from the channel
   input  wire logic i_pin,
   input  wire logic i_oe,
   // Overload request and fault line
   input  wire logic i_trip,
   output logic      o_fault_n,
   output logic      o_level
);
   logic flt_n_q = 1'b1;
   // A released pin is pulled down by the load.
   assign o_level = i_oe ? i_pin : 1'b0;
   // The fault stays low for as long as the overload lasts.
   always @(posedge i_clk_sys) begin
      flt_n_q <= !i_trip;
   end
   assign o_fault_n = flt_n_q;
endmodule

// ### test/testbench.sv
// Self-checking testbench for the output compare channel.
module testbench
   import ocm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Signals
   localparam logic [15:0] PER = 16'h003f;
   typedef struct packed {
      logic [2:0]  mode;
      logic        tsel;
      logic [15:0] prim;
      logic        e_mid;
      logic        e_end;
   } ocm_row_t;
   ocm_row_t rows [7] = '{
      '{OCM_MODE_HIGH,   1'b0, 16'h0030, 1'b0, 1'b1},
      '{OCM_MODE_LOW,    1'b0, 16'h0030, 1'b1, 1'b0},
      '{OCM_MODE_TOGGLE, 1'b1, 16'h0030, 1'b1, 1'b1},
      '{OCM_MODE_LOW,    1'b0, 16'h0050, 1'b1, 1'b1},
      '{OCM_MODE_TOGGLE, 1'b0, 16'h0030, 1'b1, 1'b0},
      '{OCM_MODE_OFF,    1'b0, 16'h0030, 1'b0, 1'b0},
      '{OCM_MODE_HIGH,   1'b1, 16'h0030, 1'b1, 1'b1}};
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic [3:0]  adr = 4'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [3:0]  be = 4'hf;
   logic [31:0] wd = 32'h0;
   logic [15:0] cnt = 16'h0;
   logic        run = 1'b0;
   logic        clr = 1'b0;
   logic        trip = 1'b0;
   logic [31:0] rdat;
   logic        wreq, pin, oe, fault_n, level;
   wire  logic [15:0] cnt_b = cnt + 16'h0020;
   int          num_errors = 0;
   int          n_compared = 0;
   always #20 clk = !clk;
   always @(posedge clk) begin
      if (clr) begin
         cnt <= 16'h0000;
      end else if (run) begin
         cnt <= (cnt == PER) ? 16'h0000 : cnt + 16'h0001;
      end
   end
   ocm_channel ocm_channel_inst (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(be),
      .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
      .i_timer_a_count(cnt), .i_timer_b_count(cnt_b), .i_fault_input_n(fault_n),
      .o_compare_output_pin(pin), .o_compare_output_oe(oe));
   ocm_load ocm_load_inst (.i_clk_sys(clk), .i_pin(pin), .i_oe(oe), .i_trip(trip),
      .o_fault_n(fault_n), .o_level(level));
   // ==========
   // Tasks
   task automatic chk_val(input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: expected %h, got %h", $time, e, g);
      end
   endtask
   task automatic chk_pin(input logic e, input logic g);
      chk_val({31'h0, e}, {31'h0, g});
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] q);
      @(posedge clk);
      adr <= a;
      wd <= d;
      be <= b;
      wr <= w;
      rd <= !w;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'hf, q);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hf, q);
      chk_val(e, q);
   endtask
   task automatic wait_cnt(input logic [15:0] v);
      do @(negedge clk); while (cnt !== v);
   endtask
   task automatic stop();
      @(posedge clk);
      run <= 1'b0;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask
   task automatic start();
      @(posedge clk);
      run <= 1'b1;
   endtask
   task automatic pulse_chk(input logic e);
      wait_cnt(16'h0008);
      chk_pin(1'b0, pin);
      wait_cnt(16'h0018);
      chk_pin(e, pin);
      wait_cnt(16'h0028);
      chk_pin(1'b0, pin);
   endtask
   task automatic wrap_up();
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #400000;
      num_errors++;
      wrap_up();
   end
   // ==========
   // Main sequence
   initial begin
      logic [31:0] q;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk_pin(1'b0, pin);
      chk_pin(1'b1, oe);
      rd_chk(OCM_ADDR_CTRL, 32'h0);
      rd_chk(OCM_ADDR_PRIMARY, 32'h0);
      rd_chk(4'h2, 32'h0);
      bus(1'b1, OCM_ADDR_SECONDARY, 32'habcd1234, 4'h1, q);
      rd_chk(OCM_ADDR_SECONDARY, 32'h0034);
      foreach (rows[i]) begin
         stop();
         wr_reg(OCM_ADDR_PRIMARY, {16'h0, rows[i].prim});
         wr_reg(OCM_ADDR_CTRL, {28'h0, rows[i].tsel, rows[i].mode});
         start();
         wait_cnt(16'h0014);
         chk_pin(rows[i].e_mid, pin);
         wait_cnt(PER);
         wait_cnt(16'h0004);
         chk_pin(rows[i].e_end, pin);
         rd_chk(OCM_ADDR_CTRL, {28'h0, rows[i].tsel, rows[i].mode});
      end
      stop();
      wr_reg(OCM_ADDR_PRIMARY, 32'h0010);
      wr_reg(OCM_ADDR_SECONDARY, 32'h0020);
      wr_reg(OCM_ADDR_CTRL, {29'h0, OCM_MODE_SINGLE});
      start();
      pulse_chk(1'b1);
      pulse_chk(1'b0);
      rd_chk(OCM_ADDR_STATUS, 32'h0006);
      wr_reg(OCM_ADDR_CTRL, {29'h0, OCM_MODE_SINGLE});
      pulse_chk(1'b1);
      wr_reg(OCM_ADDR_CTRL, {29'h0, OCM_MODE_CONT});
      pulse_chk(1'b1);
      pulse_chk(1'b1);
      stop();
      wr_reg(OCM_ADDR_SECONDARY, 32'h0018);
      wr_reg(OCM_ADDR_CTRL, {29'h0, OCM_MODE_PWM});
      start();
      wait_cnt(PER);
      wait_cnt(16'h0008);
      chk_pin(1'b1, pin);
      wait_cnt(16'h001c);
      chk_pin(1'b0, pin);
      wr_reg(OCM_ADDR_PRIMARY, 32'h0005);
      rd_chk(OCM_ADDR_PRIMARY, 32'h0018);
      wr_reg(OCM_ADDR_SECONDARY, 32'h0030);
      rd_chk(OCM_ADDR_PRIMARY, 32'h0018);
      wait_cnt(PER);
      wait_cnt(16'h0028);
      chk_pin(1'b1, pin);
      rd_chk(OCM_ADDR_PRIMARY, 32'h0030);
      wr_reg(OCM_ADDR_CTRL, {29'h0, OCM_MODE_PWM_FLT});
      wait_cnt(16'h0008);
      chk_pin(1'b1, level);
      @(posedge clk);
      trip <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk_pin(1'b0, oe);
      chk_pin(1'b0, level);
      rd_chk(OCM_ADDR_CTRL, 32'h0017);
      wr_reg(OCM_ADDR_CTRL, {29'h0, OCM_MODE_PWM_FLT});
      @(negedge clk);
      chk_pin(1'b0, oe);
      @(posedge clk);
      trip <= 1'b0;
      repeat (3) @(negedge clk);
      chk_pin(1'b0, oe);
      wr_reg(OCM_ADDR_CTRL, {29'h0, OCM_MODE_PWM_FLT});
      @(negedge clk);
      chk_pin(1'b1, oe);
      rd_chk(OCM_ADDR_CTRL, 32'h0007);
      @(posedge clk);
      rst <= 1'b1;
      @(negedge clk);
      chk_pin(1'b0, pin);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_chk(OCM_ADDR_CTRL, 32'h0);
      wrap_up();
   end
endmodule
